/* core/waveform_memory_hub.sv */
// Waveform memory hub: executive, display and digitizer access to two-bank waveform memory
// Overview of operation
// - Mode register answers at I/O 0x1860
// - Bits 0 and 1 enable display
// - Bits 5 and 6 enable digitizer
// - Bit 7 exposes generator and refresh registers
// - Each subsystem has its own handshake lines
// - Display uses 16-bit path, sequential addresses
// - Even and odd banks, separately buffered
// - Digitizer reads use sequential addressing, writes go to the strobed address
// - Digitizer side: inputs, interrupts, data ready
// - Executive gets memory and control access
`timescale 1ns/1ps
module waveform_memory_hub
#(
  parameter int ADDR_W = 20
)
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] exec_io_addr_i,
  input  wire logic        exec_io_wr_i,
  input  wire logic        exec_io_rd_i,
  input  wire logic [7:0]  exec_io_wdata_i,
  output logic      [7:0]  exec_io_rdata_o,
  input  wire logic        exec_mem_req_i,
  input  wire logic        exec_mem_we_i,
  input  wire logic [15:0] exec_mem_wdata_i,
  output logic             exec_mem_ack_o,
  output logic      [15:0] exec_mem_rdata_o,
  input  wire logic        disp_req_i,
  input  wire logic        disp_write_i,
  input  wire logic [15:0] display_data_lines_i,
  output logic      [15:0] display_data_lines_o,
  output logic             display_data_lines_oe_n_o,
  output logic             disp_ack_o,
  input  wire logic [19:0] dig_ad_i,
  input  wire logic        dig_addr_stb_i,
  input  wire logic        dig_data_stb_i,
  input  wire logic        dig_rd_req_i,
  input  wire logic        dig_taken_i,
  output logic             dig_ack_o,
  output logic      [15:0] dig_data_o,
  output logic             dig_data_ready_o,
  output logic             dig_done_irq_o,
  output logic             dig_msg_irq_o
);
  import waveform_memory_hub_pkg::*;

  localparam int DEPTH = 2 ** (ADDR_W - 1);
  // Bus and data pins take the same two stages as their strobes
  localparam int DSYNC_W = 78;

  typedef struct packed {
    logic [7:0]          mode;
    logic [SYNC_W-1:0]   sync1;
    logic [SYNC_W-1:0]   sync2;
    logic [SYNC_W-1:0]   sync3;
    logic [DSYNC_W-1:0]  dsync1;
    logic [DSYNC_W-1:0]  dsync2;
    logic [7:0]          io_rdata;
    logic [19:0]         sag_addr;
    logic [15:0]         sag_cnt;
    logic                done;
    logic [19:0]         rag_addr;
    logic [11:0]         rfs_timer;
    logic [7:0]          rfs_row;
    logic                rfs_pend;
    logic [19:0]         dig_addr;
    logic [15:0]         dig_wdata;
    logic                dig_wpend;
    logic                dig_rpend;
    logic                dig_ack;
    logic                dig_msg;
    logic                disp_pend;
    logic                disp_dir;
    logic                disp_drive;
    logic [15:0]         disp_wdata;
    logic [15:0]         disp_rdata;
    logic                disp_ack;
    logic                exec_pend;
    logic                exec_we;
    logic [15:0]         exec_wdata;
    logic [15:0]         exec_rdata;
    logic                exec_ack;
    hub_state_type       state;
    read_src_type        rd_src;
    logic                rd_odd;
    logic [15:0]         buf0;
    logic [15:0]         buf1;
    logic [1:0]          buf_cnt;
  } hub_regs_type;

  hub_regs_type r;
  hub_regs_type next_r;
  logic [SYNC_W-1:0] rise;
  logic [15:0]       io_addr_s;
  logic [7:0]        io_wdata_s;
  logic              mem_we_s;
  logic [15:0]       mem_wdata_s;
  logic              disp_write_s;
  logic [15:0]       disp_data_s;
  logic [19:0]       dig_ad_s;
  logic              disp_en;
  logic              dig_en;
  logic              g_rfs;
  logic              g_dw;
  logic              g_dr;
  logic              g_dp;
  logic              g_ex;
  logic              mem_we;
  logic [19:0]       mem_addr;
  logic [15:0]       mem_wdata;
  logic [15:0]       q_even;
  logic [15:0]       q_odd;
  logic [15:0]       mem_q;
  logic [15:0]       bank_even [DEPTH];
  logic [15:0]       bank_odd  [DEPTH];

  function automatic logic [7:0] io_read(input hub_regs_type s, input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == IO_MODE)
      v = s.mode;
    else if (s.mode[MODE_HIDDEN])
    begin
      case (a)
        IO_SAG_ADDR0: v = s.sag_addr[7:0];
        IO_SAG_ADDR1: v = s.sag_addr[15:8];
        IO_SAG_ADDR2: v = {4'h0, s.sag_addr[19:16]};
        IO_SAG_CNT0:  v = s.sag_cnt[7:0];
        IO_SAG_CNT1:  v = s.sag_cnt[15:8];
        IO_RAG_ADDR0: v = s.rag_addr[7:0];
        IO_RAG_ADDR1: v = s.rag_addr[15:8];
        IO_RAG_ADDR2: v = {4'h0, s.rag_addr[19:16]};
        IO_REFRESH:   v = s.rfs_row;
        default:      v = 8'h00;
      endcase
    end
    return v;
  endfunction

  assign rise    = r.sync2 & ~r.sync3;
  assign {io_addr_s, io_wdata_s, mem_we_s, mem_wdata_s, disp_write_s, disp_data_s, dig_ad_s} = r.dsync2;
  assign disp_en = r.mode[MODE_DISP_A] & r.mode[MODE_DISP_B];
  assign dig_en  = r.mode[MODE_DIG_A] & r.mode[MODE_DIG_B];
  assign mem_q   = r.rd_odd ? q_odd : q_even;

  always_comb
  begin
    next_r = r;
    g_rfs = 1'b0;
    g_dw = 1'b0;
    g_dr = 1'b0;
    g_dp = 1'b0;
    g_ex = 1'b0;
    mem_we = 1'b0;
    mem_addr = r.sag_addr;
    mem_wdata = r.disp_wdata;
    next_r.sync1 = {exec_mem_req_i, dig_taken_i, dig_rd_req_i, dig_data_stb_i,
                    dig_addr_stb_i, disp_req_i, exec_io_rd_i, exec_io_wr_i};
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    next_r.dsync1 = {exec_io_addr_i, exec_io_wdata_i, exec_mem_we_i, exec_mem_wdata_i,
                     disp_write_i, display_data_lines_i, dig_ad_i};
    next_r.dsync2 = r.dsync1;
    // Release lines once the display lets go, so a later write meets no contention
    if (!r.sync2[S_DISP])
      next_r.disp_drive = 1'b0;
    next_r.dig_ack = 1'b0;
    next_r.dig_msg = 1'b0;
    next_r.disp_ack = 1'b0;
    next_r.exec_ack = 1'b0;
    if (rise[S_IO_RD])
      next_r.io_rdata = io_read(r, io_addr_s);
    if (rise[S_IO_WR])
    begin
      if (io_addr_s == IO_MODE)
        next_r.mode = io_wdata_s;
      else if (r.mode[MODE_HIDDEN])
      begin
        case (io_addr_s)
          IO_SAG_ADDR0: next_r.sag_addr[7:0] = io_wdata_s;
          IO_SAG_ADDR1: next_r.sag_addr[15:8] = io_wdata_s;
          IO_SAG_ADDR2: next_r.sag_addr[19:16] = io_wdata_s[3:0];
          IO_SAG_CNT0:  next_r.sag_cnt[7:0] = io_wdata_s;
          IO_SAG_CNT1:  next_r.sag_cnt[15:8] = io_wdata_s;
          IO_RAG_ADDR0: next_r.rag_addr[7:0] = io_wdata_s;
          IO_RAG_ADDR1: next_r.rag_addr[15:8] = io_wdata_s;
          IO_RAG_ADDR2: next_r.rag_addr[19:16] = io_wdata_s[3:0];
          default:      next_r.rfs_row = r.rfs_row;
        endcase
        if (io_addr_s == IO_SAG_CNT0 || io_addr_s == IO_SAG_CNT1)
          next_r.done = 1'b0;
      end
    end
    if (r.rfs_timer == 12'h000)
    begin
      next_r.rfs_pend = 1'b1;
      next_r.rfs_timer = REFRESH_CYCLES - 12'h001;
    end
    else
      next_r.rfs_timer = r.rfs_timer - 12'h001;
    // Digitizer strobe pulls the oldest word out of the buffer
    if (rise[S_DIG_TAKEN] && r.buf_cnt != 2'h0)
    begin
      next_r.buf0 = r.buf1;
      next_r.buf_cnt = r.buf_cnt - 2'h1;
    end
    case (r.state)
      ST_IDLE:
      begin
        // Refresh first so a busy stream cannot starve the DRAM
        if (r.rfs_pend)
          g_rfs = 1'b1;
        else if (r.dig_wpend && dig_en)
          g_dw = 1'b1;
        else if (r.dig_rpend && dig_en && r.sag_cnt != 16'h0000 && r.buf_cnt != 2'h2)
          g_dr = 1'b1;
        else if (r.disp_pend && disp_en && r.sag_cnt != 16'h0000)
          g_dp = 1'b1;
        else if (r.exec_pend)
          g_ex = 1'b1;
        if (g_rfs)
        begin
          next_r.rfs_pend = 1'b0;
          next_r.rfs_row = r.rfs_row + 8'h01;
        end
        if (g_dw)
        begin
          mem_we = 1'b1;
          mem_addr = r.dig_addr;
          mem_wdata = r.dig_wdata;
          next_r.dig_wpend = 1'b0;
          next_r.dig_ack = 1'b1;
          next_r.dig_msg = 1'b1;
        end
        if (g_ex)
        begin
          mem_addr = r.rag_addr;
          mem_wdata = r.exec_wdata;
          mem_we = r.exec_we;
          next_r.exec_pend = 1'b0;
          next_r.exec_ack = r.exec_we;
          next_r.rd_src = SRC_EXEC;
          if (!r.exec_we)
            next_r.state = ST_READ;
        end
        if (g_dr || g_dp)
        begin
          mem_we = g_dp & r.disp_dir;
          next_r.sag_addr = r.sag_addr + 20'h00001;
          next_r.sag_cnt = (r.sag_cnt < 16'h0002) ? 16'h0000 : r.sag_cnt - 16'h0002;
          if (r.sag_cnt <= 16'h0002)
            next_r.done = 1'b1;
          next_r.dig_rpend = r.dig_rpend & ~g_dr;
          next_r.disp_pend = r.disp_pend & ~g_dp;
          next_r.disp_ack = g_dp & r.disp_dir;
          next_r.rd_src = g_dr ? SRC_DIG : SRC_DISP;
          if (!(g_dp && r.disp_dir))
            next_r.state = ST_READ;
        end
        next_r.rd_odd = mem_addr[0];
      end
      ST_READ:
      begin
        next_r.state = ST_IDLE;
        case (r.rd_src)
          SRC_DIG:
          begin
            if (next_r.buf_cnt == 2'h0)
              next_r.buf0 = mem_q;
            else
              next_r.buf1 = mem_q;
            next_r.buf_cnt = next_r.buf_cnt + 2'h1;
          end
          SRC_DISP:
          begin
            next_r.disp_rdata = mem_q;
            next_r.disp_ack = 1'b1;
          end
          default:
          begin
            next_r.exec_rdata = mem_q;
            next_r.exec_ack = 1'b1;
          end
        endcase
      end
      default: next_r.state = ST_IDLE;
    endcase
    // New requests are captured after the grants so that a set wins over a clear
    if (rise[S_DISP])
    begin
      next_r.disp_pend = 1'b1;
      next_r.disp_dir = disp_write_s;
      next_r.disp_drive = ~disp_write_s;
      next_r.disp_wdata = disp_data_s;
    end
    if (rise[S_DIG_ASTB])
      next_r.dig_addr = dig_ad_s;
    if (rise[S_DIG_DSTB])
    begin
      next_r.dig_wdata = dig_ad_s[15:0];
      next_r.dig_wpend = 1'b1;
    end
    if (rise[S_DIG_RREQ])
      next_r.dig_rpend = 1'b1;
    if (rise[S_EXEC])
    begin
      next_r.exec_pend = 1'b1;
      next_r.exec_we = mem_we_s;
      next_r.exec_wdata = mem_wdata_s;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      r <= '0;
      r.mode <= MODE_RESET;
      r.rfs_timer <= REFRESH_CYCLES;
      r.state <= ST_IDLE;
      r.rd_src <= SRC_DIG;
    end
    else
      r <= next_r;
  end

  // Banks have no reset; contents are undefined until written
  always_ff @(posedge clk_i)
  begin
    if (mem_we && mem_addr[0])
      bank_odd[mem_addr[ADDR_W-1:1]] <= mem_wdata;
    if (mem_we && !mem_addr[0])
      bank_even[mem_addr[ADDR_W-1:1]] <= mem_wdata;
    q_odd <= bank_odd[mem_addr[ADDR_W-1:1]];
    q_even <= bank_even[mem_addr[ADDR_W-1:1]];
  end

  assign exec_io_rdata_o = r.io_rdata;
  assign exec_mem_ack_o = r.exec_ack;
  assign exec_mem_rdata_o = r.exec_rdata;
  assign display_data_lines_o = r.disp_rdata;
  assign display_data_lines_oe_n_o = ~(r.sync2[S_DISP] & r.disp_drive);
  assign disp_ack_o = r.disp_ack;
  assign dig_ack_o = r.dig_ack;
  assign dig_data_o = r.buf0;
  assign dig_data_ready_o = (r.buf_cnt != 2'h0);
  assign dig_done_irq_o = r.done;
  assign dig_msg_irq_o = r.dig_msg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_mode_read;
    rise[S_IO_RD] && io_addr_s == IO_MODE |=> exec_io_rdata_o == $past(r.mode);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode register read wrong");
  property p_hidden;
    rise[S_IO_RD] && io_addr_s == IO_SAG_CNT0 && !r.mode[MODE_HIDDEN] |=> exec_io_rdata_o == 8'h00;
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden register visible");
  property p_disp_gate;
    g_dp |-> r.mode[MODE_DISP_A] && r.mode[MODE_DISP_B];
  endproperty
  a_disp_gate: assert property (p_disp_gate) else $error("display served while disabled");
  property p_dig_gate;
    (g_dw || g_dr) |-> r.mode[MODE_DIG_A] && r.mode[MODE_DIG_B];
  endproperty
  a_dig_gate: assert property (p_dig_gate) else $error("digitizer served while disabled");
  property p_one_grant;
    $onehot0({g_rfs, g_dw, g_dr, g_dp, g_ex}) && !(r.state == ST_READ && (g_rfs || g_dw || g_dr || g_dp || g_ex));
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("more than one grant");
  property p_refresh;
    r.rfs_pend |-> ##[1:3] !r.rfs_pend;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh not served");
  property p_sag_step;
    (g_dr || g_dp) |=> r.sag_addr == $past(r.sag_addr) + 20'h00001;
  endproperty
  a_sag_step: assert property (p_sag_step) else $error("sequential address not stepped");
  property p_dig_write;
    g_dw |-> mem_we && mem_addr == r.dig_addr ##1 dig_ack_o;
  endproperty
  a_dig_write: assert property (p_dig_write) else $error("digitizer write not done");
  property p_dig_read;
    g_dr && r.buf_cnt == 2'h0 && !rise[S_DIG_TAKEN] |-> ##2 dig_data_ready_o;
  endproperty
  a_dig_read: assert property (p_dig_read) else $error("digitizer data not ready");
  property p_exec_read;
    g_ex && !r.exec_we |-> ##2 exec_mem_ack_o;
  endproperty
  a_exec_read: assert property (p_exec_read) else $error("executive read not answered");
  c_buf_full: cover property (r.buf_cnt == 2'h2);
  c_disp_read: cover property (g_dp && !r.disp_dir ##2 disp_ack_o);
  c_refresh_clash: cover property (g_rfs && r.dig_wpend);
endmodule

/* core/waveform_memory_hub_pkg.sv */
// Constants shared by the waveform memory transfer hub
package waveform_memory_hub_pkg;
  localparam logic [15:0] IO_MODE       = 16'h1860;
  localparam logic [15:0] IO_SAG_ADDR0  = 16'h1861;
  localparam logic [15:0] IO_SAG_ADDR1  = 16'h1862;
  localparam logic [15:0] IO_SAG_ADDR2  = 16'h1863;
  localparam logic [15:0] IO_SAG_CNT0   = 16'h1864;
  localparam logic [15:0] IO_SAG_CNT1   = 16'h1865;
  localparam logic [15:0] IO_RAG_ADDR0  = 16'h1866;
  localparam logic [15:0] IO_RAG_ADDR1  = 16'h1867;
  localparam logic [15:0] IO_RAG_ADDR2  = 16'h1868;
  localparam logic [15:0] IO_REFRESH    = 16'h1869;
  localparam int          MODE_DISP_A   = 0;
  localparam int          MODE_DISP_B   = 1;
  localparam int          MODE_DIG_A    = 5;
  localparam int          MODE_DIG_B    = 6;
  localparam int          MODE_HIDDEN   = 7;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam int          CLK_MHZ       = 250;
  localparam int          REFRESH_NS    = 15600;
  localparam logic [11:0] REFRESH_CYCLES = 12'((REFRESH_NS * CLK_MHZ) / 1000);
  localparam int          SYNC_W        = 8;
  localparam int          S_IO_WR       = 0;
  localparam int          S_IO_RD       = 1;
  localparam int          S_DISP        = 2;
  localparam int          S_DIG_ASTB    = 3;
  localparam int          S_DIG_DSTB    = 4;
  localparam int          S_DIG_RREQ    = 5;
  localparam int          S_DIG_TAKEN   = 6;
  localparam int          S_EXEC        = 7;
  typedef enum {ST_IDLE, ST_READ} hub_state_type;
  typedef enum logic [1:0] {SRC_DIG = 2'h0, SRC_DISP = 2'h1, SRC_EXEC = 2'h2} read_src_type;
endpackage

/* bench/dig_proc_model.sv */
// Digitizer processor model on the multiplexed address/data bus
`timescale 1ns/1ps
module dig_proc_model
(
  input  wire logic        clk_i,
  input  wire logic        dig_data_ready_i,
  input  wire logic [15:0] dig_data_i,
  output logic      [19:0] dig_ad_o,
  output logic             dig_addr_stb_o,
  output logic             dig_data_stb_o,
  output logic             dig_rd_req_o,
  output logic             dig_taken_o
);
  initial
  begin
    dig_ad_o = 20'h00000;
    dig_addr_stb_o = 1'b0;
    dig_data_stb_o = 1'b0;
    dig_rd_req_o = 1'b0;
    dig_taken_o = 1'b0;
  end

  // Strobes stay high past the hub's two-stage synchroniser
  task automatic pulse(input logic [19:0] v, input bit is_data);
    @(negedge clk_i);
    dig_ad_o = v;
    if (is_data)
      dig_data_stb_o = 1'b1;
    else
      dig_addr_stb_o = 1'b1;
    repeat (4) @(negedge clk_i);
    dig_addr_stb_o = 1'b0;
    dig_data_stb_o = 1'b0;
    // No stale value once the hold is over
    dig_ad_o = ~v;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic write_word(input logic [19:0] addr, input logic [15:0] data);
    pulse(addr, 1'b0);
    pulse({4'h0, data}, 1'b1);
  endtask

  task automatic read_word(output logic [15:0] data, output bit ok);
    int n;
    ok = 1'b0;
    @(negedge clk_i);
    dig_rd_req_o = 1'b1;
    repeat (4) @(negedge clk_i);
    dig_rd_req_o = 1'b0;
    for (n = 0; n < 60 && !ok; n++)
    begin
      @(negedge clk_i);
      ok = (dig_data_ready_i === 1'b1);
    end
    data = dig_data_i;
    dig_taken_o = 1'b1;
    repeat (4) @(negedge clk_i);
    dig_taken_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

/* bench/waveform_memory_transfer_hub_bench.sv */
// Self-checking bench for the waveform memory hub
`timescale 1ns/1ps
module waveform_memory_transfer_hub_bench;
  import waveform_memory_hub_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  io_rdata;
  logic        mem_req = 1'b0;
  logic        mem_we = 1'b0;
  logic [15:0] mem_wdata = 16'h0000;
  logic        mem_ack;
  logic [15:0] mem_rdata;
  logic        disp_req = 1'b0;
  logic        disp_write = 1'b0;
  logic [15:0] disp_drv = 16'hFFFF;
  logic [15:0] disp_out;
  logic        disp_oe_n;
  logic        disp_ack;
  logic [15:0] disp_wire;
  logic [19:0] dig_ad;
  logic        dig_astb, dig_dstb, dig_rreq, dig_taken, dig_ack;
  logic [15:0] dig_data;
  logic        dig_rdy, dig_done, dig_msg, msg_seen;
  int          fails = 0;
  int          n_tests = 0;

  always #2 clk_i = ~clk_i;
  // Display drives its word when the hub lets go; idle value is the pull-up level
  assign disp_wire = disp_oe_n ? disp_drv : disp_out;

  waveform_memory_hub #(.ADDR_W(12)) i_waveform_memory_hub
  (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .exec_io_addr_i(io_addr), .exec_io_wr_i(io_wr), .exec_io_rd_i(io_rd),
    .exec_io_wdata_i(io_wdata), .exec_io_rdata_o(io_rdata),
    .exec_mem_req_i(mem_req), .exec_mem_we_i(mem_we), .exec_mem_wdata_i(mem_wdata),
    .exec_mem_ack_o(mem_ack), .exec_mem_rdata_o(mem_rdata),
    .disp_req_i(disp_req), .disp_write_i(disp_write), .display_data_lines_i(disp_wire),
    .display_data_lines_o(disp_out), .display_data_lines_oe_n_o(disp_oe_n), .disp_ack_o(disp_ack),
    .dig_ad_i(dig_ad), .dig_addr_stb_i(dig_astb), .dig_data_stb_i(dig_dstb),
    .dig_rd_req_i(dig_rreq), .dig_taken_i(dig_taken), .dig_ack_o(dig_ack),
    .dig_data_o(dig_data), .dig_data_ready_o(dig_rdy),
    .dig_done_irq_o(dig_done), .dig_msg_irq_o(dig_msg)
  );

  dig_proc_model i_dig_proc_model
  (
    .clk_i(clk_i), .dig_data_ready_i(dig_rdy), .dig_data_i(dig_data),
    .dig_ad_o(dig_ad), .dig_addr_stb_o(dig_astb), .dig_data_stb_o(dig_dstb),
    .dig_rd_req_o(dig_rreq), .dig_taken_o(dig_taken)
  );

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic io_wr_t(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    repeat (5) @(negedge clk_i);
    io_wr = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic io_rd_t(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_i);
    io_addr = a;
    io_rd = 1'b1;
    repeat (6) @(negedge clk_i);
    d = io_rdata;
    io_rd = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  // Waits for a one-cycle acknowledge: 0 executive, 1 display, 2 digitizer
  task automatic wait_ack(input int which, input int lim, output bit seen);
    int n;
    seen = 1'b0;
    for (n = 0; n < lim && !seen; n++)
    begin
      @(posedge clk_i);
      #1;
      seen = (which == 0) ? (mem_ack === 1'b1) : (which == 1) ? (disp_ack === 1'b1) : (dig_ack === 1'b1);
      msg_seen = (dig_msg === 1'b1);
    end
  endtask

  task automatic mem_acc(input logic we, input logic [15:0] wd, output logic [15:0] rd);
    bit ok;
    @(negedge clk_i);
    mem_we = we;
    mem_wdata = wd;
    mem_req = 1'b1;
    wait_ack(0, 60, ok);
    chk("exec ack", 20'h1, 20'(ok));
    rd = mem_rdata;
    @(negedge clk_i);
    mem_req = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic t_reset;
    chk("oe_n", 20'h1, 20'(disp_oe_n));
    chk("ready", 20'h0, 20'(dig_rdy));
    chk("done", 20'h0, 20'(dig_done));
  endtask

  task automatic t_regs;
    logic [7:0] d;
    io_wr_t(IO_SAG_ADDR0, 8'h55);
    io_rd_t(IO_SAG_ADDR0, d);
    chk("hidden closed", 20'h0, 20'(d));
    io_wr_t(IO_MODE, 8'h80);
    io_rd_t(IO_MODE, d);
    chk("mode", 20'h80, 20'(d));
    io_wr_t(IO_SAG_ADDR0, 8'h55);
    io_rd_t(IO_SAG_ADDR0, d);
    chk("hidden open", 20'h55, 20'(d));
    io_rd_t(16'h1859, d);
    chk("unmapped", 20'h0, 20'(d));
  endtask

  task automatic t_dig_write;
    bit ok;
    io_wr_t(IO_SAG_ADDR0, 8'h10);
    io_wr_t(IO_SAG_ADDR1, 8'h00);
    io_wr_t(IO_SAG_CNT0, 8'h04);
    io_wr_t(IO_SAG_CNT1, 8'h00);
    io_wr_t(IO_RAG_ADDR0, 8'h10);
    io_wr_t(IO_RAG_ADDR1, 8'h00);
    i_dig_proc_model.write_word(20'h00010, 16'h1234);
    wait_ack(2, 30, ok);
    chk("write held", 20'h0, 20'(ok));
    fork
      io_wr_t(IO_MODE, 8'hE1);
      wait_ack(2, 60, ok);
    join
    chk("write done", 20'h1, 20'(ok));
    chk("msg irq", 20'h1, 20'(msg_seen));
    fork
      i_dig_proc_model.write_word(20'h00011, 16'hABCD);
      wait_ack(2, 60, ok);
    join
    chk("odd write", 20'h1, 20'(ok));
  endtask

  task automatic t_disp;
    bit ok;
    @(negedge clk_i);
    disp_req = 1'b1;
    wait_ack(1, 30, ok);
    chk("disp held", 20'h0, 20'(ok));
    fork
      io_wr_t(IO_MODE, 8'hE3);
      wait_ack(1, 60, ok);
    join
    chk("disp ack", 20'h1, 20'(ok));
    chk("disp data", 20'h1234, 20'(disp_out));
    chk("oe_n drive", 20'h0, 20'(disp_oe_n));
    @(negedge clk_i);
    disp_req = 1'b0;
    repeat (6) @(negedge clk_i);
    chk("oe_n off", 20'h1, 20'(disp_oe_n));
  endtask

  task automatic t_dig_read;
    logic [15:0] d;
    bit ok;
    i_dig_proc_model.read_word(d, ok);
    chk("rd ready", 20'h1, 20'(ok));
    chk("rd data", 20'hABCD, 20'(d));
    chk("ready low", 20'h0, 20'(dig_rdy));
    chk("done irq", 20'h1, 20'(dig_done));
  endtask

  task automatic t_exec;
    logic [15:0] d;
    mem_acc(1'b0, 16'h0000, d);
    chk("exec rd", 20'h1234, 20'(d));
    mem_acc(1'b1, 16'h5A5A, d);
    mem_acc(1'b0, 16'h0000, d);
    chk("exec wr", 20'h5A5A, 20'(d));
  endtask

  task automatic t_disp_wr;
    logic [15:0] d;
    bit ok;
    io_wr_t(IO_SAG_CNT0, 8'h02);
    chk("done cleared", 20'h0, 20'(dig_done));
    io_wr_t(IO_RAG_ADDR0, 8'h12);
    @(negedge clk_i);
    disp_drv = 16'hC3C3;
    disp_write = 1'b1;
    disp_req = 1'b1;
    wait_ack(1, 60, ok);
    chk("disp wr ack", 20'h1, 20'(ok));
    chk("disp wr oe_n", 20'h1, 20'(disp_oe_n));
    @(negedge clk_i);
    disp_req = 1'b0;
    repeat (6) @(negedge clk_i);
    disp_write = 1'b0;
    disp_drv = 16'hFFFF;
    chk("disp wr done", 20'h1, 20'(dig_done));
    mem_acc(1'b0, 16'h0000, d);
    chk("disp wr data", 20'hC3C3, 20'(d));
  endtask

  // Two reads exactly one refresh period apart see exactly one row step
  task automatic t_refresh;
    logic [7:0] r0;
    logic [7:0] r1;
    io_rd_t(IO_REFRESH, r0);
    repeat (REFRESH_CYCLES - 12'h00B) @(negedge clk_i);
    io_rd_t(IO_REFRESH, r1);
    chk("refresh rows", 20'(r0 + 8'h01), 20'(r1));
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_regs();
    t_dig_write();
    t_disp();
    t_dig_read();
    t_exec();
    t_disp_wr();
    t_refresh();
    close_out();
  end

  initial
  begin
    #160000;
    fails++;
    close_out();
  end
endmodule
